// *** rtl/usync_pkg.sv ***
// constants shared by both ends of the synchronous slave receive link
//
// Overview of operation
// - slave receive works like master receive, except sleep
// - single-receive enable is ignored in slave mode
// - continuous enable set before sleep keeps receiving
// - finished word moves from shift register to buffer
// - enabled receive interrupt wakes chip from sleep
// - after wake, global enable branches to fixed vector
// - software sets sync and port enable, clears source
// - nine-bit select adds ninth bit shown in status
// - reception starts only after continuous enable is set
// - word done sets flag; request only when enabled
// - status shows ninth bit, framing, overrun; read first
// - buffer read delivers low eight data bits
// - clearing continuous enable clears latched errors
// - request needs global and peripheral enables too
// - software keeps reserved parallel-port bits cleared
// - external master drives shift clock; device never does
// - buffer read brings next word's ninth bit forward
package usync_pkg;

  // register offsets on the device's register port
  localparam logic [7:0] ADDR_INTERRUPT_CONTROL  = 8'h0B;
  localparam logic [7:0] ADDR_PERIPH_IRQ_FLAGS   = 8'h0C;
  localparam logic [7:0] ADDR_RECEIVE_STATUS     = 8'h18;
  localparam logic [7:0] ADDR_RECEIVE_DATA       = 8'h1A;
  localparam logic [7:0] ADDR_PERIPH_IRQ_ENABLES = 8'h8C;
  localparam logic [7:0] ADDR_TRANSMIT_STATUS    = 8'h98;
  localparam logic [7:0] ADDR_BIT_RATE_DIVISOR   = 8'h99;

  // reset values
  localparam logic [7:0] RST_INTERRUPT_CONTROL  = 8'h00;
  localparam logic [7:0] RST_PERIPH_IRQ_FLAGS   = 8'h00;
  localparam logic [7:0] RST_RECEIVE_STATUS     = 8'h00;
  localparam logic [7:0] RST_PERIPH_IRQ_ENABLES = 8'h00;
  localparam logic [7:0] RST_TRANSMIT_STATUS    = 8'h02;
  localparam logic [7:0] RST_BIT_RATE_DIVISOR   = 8'h00;

  // field positions
  localparam int unsigned BIT_GLOBAL_IRQ_ENABLE     = 7;
  localparam int unsigned BIT_PERIPHERAL_IRQ_ENABLE = 6;
  localparam int unsigned BIT_RECEIVE_IRQ_FLAG      = 5;
  localparam int unsigned BIT_RECEIVE_IRQ_ENABLE    = 5;
  localparam int unsigned BIT_SERIAL_PORT_ENABLE    = 7;
  localparam int unsigned BIT_NINE_BIT_SELECT       = 6;
  localparam int unsigned BIT_CONT_RECEIVE_ENABLE   = 4;
  localparam int unsigned BIT_CLOCK_SOURCE_SELECT   = 7;
  localparam int unsigned BIT_SYNC_MODE             = 4;
  localparam int unsigned BIT_TRANSMIT_EMPTY        = 1;

  // writable bits of the flag, receive status and transmit status registers
  localparam logic [7:0] MASK_PERIPH_IRQ_FLAGS = 8'hDF;
  localparam logic [7:0] MASK_RECEIVE_STATUS   = 8'hF8;
  localparam logic [7:0] MASK_TRANSMIT_STATUS  = 8'hFD;

  localparam logic [12:0] IRQ_VECTOR = 13'h0004;

  localparam int unsigned DATA_W    = 8;
  localparam int unsigned WORD_W    = 9;
  localparam logic [3:0]  LAST_BIT8 = 4'h7;
  localparam logic [3:0]  LAST_BIT9 = 4'h8;
  localparam int unsigned BUF_DEPTH = 2;

  // master half period in clk cycles: 2 gives a 40 ns shift clock at 100 MHz
  localparam int unsigned MASTER_HALF_CYCLES = 2;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_LOW  = 2'b01,
    ST_HIGH = 2'b10
  } master_state_t;

endpackage

// *** rtl/sync_link_if.sv ***
// shift clock and data wires between the external master and the receiver
`timescale 1ns/1ns
interface sync_link_if;
  logic shift_clk;
  logic data;

  modport master
  (
    output shift_clk,
    output data
  );

  modport device
  (
    input  shift_clk,
    input  data
  );
endinterface

// *** rtl/usync_master_tx.sv ***
// external synchronous master: shifts words out and makes the shift clock
`timescale 1ns/1ns
module usync_master_tx
  import usync_pkg::*;
#(
  parameter int unsigned HALF_CYCLES = MASTER_HALF_CYCLES
)
(
  input  wire logic                clk,
  input  wire logic                rst,
  sync_link_if.master              link,
  input  wire logic                word_valid,
  input  wire logic [WORD_W-1:0]   word_data,
  input  wire logic                nine_bit,
  output logic                     word_ready
);

  if (HALF_CYCLES < 1 || HALF_CYCLES > 255)
  begin : g_bad_half
    $error("HALF_CYCLES must be 1 to 255");
  end

  localparam logic [7:0] HALF_LAST = 8'(HALF_CYCLES - 1);

  master_state_t     state_q, state_d;
  logic [7:0]        div_q, div_d;
  logic [3:0]        bit_q, bit_d, last_q, last_d;
  logic [WORD_W-1:0] sh_q, sh_d;
  logic              clk_q, clk_d, data_q, data_d, ready_q, ready_d;

  wire tick  = div_q == HALF_LAST;
  wire start = word_valid && ready_q;

  always_comb
  begin
    state_d = state_q;
    div_d   = tick ? 8'h00 : div_q + 8'h01;
    bit_d   = bit_q;
    last_d  = last_q;
    sh_d    = sh_q;
    clk_d   = clk_q;
    data_d  = data_q;
    ready_d = ready_q;
    case (state_q)
      ST_IDLE:
      begin
        div_d = 8'h00;
        if (start)
        begin
          state_d = ST_LOW;
          sh_d    = word_data >> 1;
          data_d  = word_data[0];
          bit_d   = 4'h0;
          last_d  = nine_bit ? LAST_BIT9 : LAST_BIT8;
          ready_d = 1'b0;
        end
      end
      ST_LOW:
        if (tick)
        begin
          clk_d   = 1'b1;
          state_d = ST_HIGH;
        end
      ST_HIGH:
        if (tick)
        begin
          clk_d = 1'b0;
          if (bit_q == last_q)
          begin
            state_d = ST_IDLE;
            ready_d = 1'b1;
          end
          else
          begin
            state_d = ST_LOW;
            bit_d   = bit_q + 4'h1;
            data_d  = sh_q[0];
            sh_d    = sh_q >> 1;
          end
        end
      default:
        state_d = ST_IDLE;
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      state_q <= ST_IDLE;
      div_q   <= 8'h00;
      bit_q   <= 4'h0;
      last_q  <= LAST_BIT8;
      sh_q    <= '0;
      clk_q   <= 1'b0;
      data_q  <= 1'b0;
      ready_q <= 1'b0;
    end
    else
    begin
      state_q <= state_d;
      div_q   <= div_d;
      bit_q   <= bit_d;
      last_q  <= last_d;
      sh_q    <= sh_d;
      clk_q   <= clk_d;
      data_q  <= data_d;
      ready_q <= (state_q == ST_IDLE && !start) ? 1'b1 : ready_d;
    end
  end

  // clock idles low between words so the receiver sees no stray edge
  assign link.shift_clk = clk_q;
  assign link.data      = data_q;
  assign word_ready     = ready_q;

endmodule

// *** rtl/usync_slave_rx.sv ***
// synchronous slave receiver: link-clocked shifter, crossing, buffer, registers
`timescale 1ns/1ns
module usync_slave_rx
  import usync_pkg::*;
#(
  parameter int unsigned DEPTH = BUF_DEPTH
)
(
  input  wire logic        clk,
  input  wire logic        rst,
  sync_link_if.device      link,
  input  wire logic [7:0]  reg_addr,
  input  wire logic [7:0]  reg_wdata,
  input  wire logic        reg_we,
  input  wire logic        reg_re,
  input  wire logic        sleep,
  output logic      [7:0]  reg_rdata,
  output logic             irq,
  output logic             wake,
  output logic      [12:0] irq_vector
);

  if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0)
  begin : g_bad_depth
    $error("DEPTH must be a power of two, at least 2");
  end

  localparam int unsigned PW = $clog2(DEPTH);
  localparam logic [PW:0] FULL_COUNT = (PW + 1)'(DEPTH);

  function automatic logic hit(input logic [7:0] addr, input logic [7:0] offset);
    hit = addr == offset;
  endfunction

  // software registers
  logic [7:0] interrupt_control_q, pflags_q, receive_status_control_q, pie_q, transmit_status_control_q, divisor_q;
  logic       nine_q, link_clr_q, overrun_error_q;
  logic [7:0] rdata_q, rdata_d;
  logic       irq_q, wake_q;
  logic [12:0] vector_q;

  wire sel_interrupt_control  = hit(reg_addr, ADDR_INTERRUPT_CONTROL);
  wire sel_pflags  = hit(reg_addr, ADDR_PERIPH_IRQ_FLAGS);
  wire sel_receive_status_control   = hit(reg_addr, ADDR_RECEIVE_STATUS);
  wire sel_rcdata  = hit(reg_addr, ADDR_RECEIVE_DATA);
  wire sel_pie     = hit(reg_addr, ADDR_PERIPH_IRQ_ENABLES);
  wire sel_transmit_status_control   = hit(reg_addr, ADDR_TRANSMIT_STATUS);
  wire sel_divisor = hit(reg_addr, ADDR_BIT_RATE_DIVISOR);

  wire global_irq_enable       = interrupt_control_q[BIT_GLOBAL_IRQ_ENABLE];
  wire peripheral_irq_enable      = interrupt_control_q[BIT_PERIPHERAL_IRQ_ENABLE];
  wire receive_irq_enable      = pie_q[BIT_RECEIVE_IRQ_ENABLE];
  wire serial_port_enable      = receive_status_control_q[BIT_SERIAL_PORT_ENABLE];
  wire continuous_receive_enable      = receive_status_control_q[BIT_CONT_RECEIVE_ENABLE];
  wire sync_mode = transmit_status_control_q[BIT_SYNC_MODE];
  wire clock_source_select      = transmit_status_control_q[BIT_CLOCK_SOURCE_SELECT];

  // single-receive enable is stored but never looked at
  wire rx_enable = serial_port_enable && sync_mode && !clock_source_select && continuous_receive_enable;

  // link domain, clocked only by the master's shift clock
  logic [3:0]        bitcnt_q;
  logic [WORD_W-1:0] shift_q, word_q;
  logic              tgl_q;

  wire last_bit = bitcnt_q == (nine_q ? LAST_BIT9 : LAST_BIT8);
  wire [WORD_W-1:0] word_d = nine_q ? {link.data, shift_q[WORD_W-1:1]}
                                    : {1'b0, link.data, shift_q[WORD_W-1:2]};

  // async clear from a clk-domain flop: the shift clock may be stopped
  // whenever software disables the receiver, so a sampled clear could stick
  always_ff @(posedge link.shift_clk or posedge link_clr_q)
  begin
    if (link_clr_q)
    begin
      bitcnt_q <= 4'h0;
      shift_q  <= '0;
      word_q   <= '0;
      tgl_q    <= 1'b0;
    end
    else
    begin
      shift_q  <= {link.data, shift_q[WORD_W-1:1]};
      bitcnt_q <= last_bit ? 4'h0 : bitcnt_q + 4'h1;
      if (last_bit)
      begin
        word_q <= word_d;
        tgl_q  <= ~tgl_q;
      end
    end
  end

  // toggle crossing; word_q is stable for a whole word time after each toggle
  logic [2:0] tsync_q;

  always_ff @(posedge clk)
  begin
    if (rst || link_clr_q)
      tsync_q <= 3'b000;
    else
      tsync_q <= {tsync_q[1:0], tgl_q};
  end

  wire word_evt = tsync_q[2] ^ tsync_q[1];

  // two-entry buffer between the crossing and the data register
  logic [WORD_W-1:0] buf_q [DEPTH];
  logic [PW-1:0]     wr_ptr_q, rd_ptr_q;
  logic [PW:0]       cnt_q;

  wire               in_valid  = word_evt;
  wire               in_ready  = cnt_q != FULL_COUNT && !overrun_error_q;
  wire               push      = in_valid && in_ready;
  wire               out_valid = cnt_q != '0;
  wire               out_ready = reg_re && sel_rcdata;
  wire               pop       = out_valid && out_ready;
  wire [WORD_W-1:0]  head      = out_valid ? buf_q[rd_ptr_q] : '0;
  wire               receive_irq_flag      = out_valid;
  wire               received_ninth_bit      = head[WORD_W-1];

  always_ff @(posedge clk)
  begin
    if (push)
      buf_q[wr_ptr_q] <= word_q;
  end

  always_ff @(posedge clk)
  begin
    if (rst || link_clr_q)
    begin
      wr_ptr_q <= '0;
      rd_ptr_q <= '0;
      cnt_q    <= '0;
    end
    else
    begin
      wr_ptr_q <= push ? wr_ptr_q + 1'b1 : wr_ptr_q;
      rd_ptr_q <= pop ? rd_ptr_q + 1'b1 : rd_ptr_q;
      cnt_q    <= cnt_q + (PW + 1)'(push) - (PW + 1)'(pop);
    end
  end

  // overrun: a new word meeting a full buffer sets it only while continuous enable is on; it clears while that enable is off
  always_ff @(posedge clk)
  begin
    if (rst)
      overrun_error_q <= 1'b0;
    else if (in_valid && !in_ready && continuous_receive_enable)
      overrun_error_q <= 1'b1;
    else if (!continuous_receive_enable)
      overrun_error_q <= 1'b0;
  end

  // register writes
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      interrupt_control_q  <= RST_INTERRUPT_CONTROL;
      pflags_q  <= RST_PERIPH_IRQ_FLAGS;
      receive_status_control_q   <= RST_RECEIVE_STATUS;
      pie_q     <= RST_PERIPH_IRQ_ENABLES;
      transmit_status_control_q   <= RST_TRANSMIT_STATUS;
      divisor_q <= RST_BIT_RATE_DIVISOR;
    end
    else if (reg_we)
    begin
      if (sel_interrupt_control)
        interrupt_control_q <= reg_wdata;
      else if (sel_pflags)
        pflags_q <= reg_wdata & MASK_PERIPH_IRQ_FLAGS;
      else if (sel_receive_status_control)
        receive_status_control_q <= reg_wdata & MASK_RECEIVE_STATUS;
      else if (sel_pie)
        pie_q <= reg_wdata;
      else if (sel_transmit_status_control)
        transmit_status_control_q <= (reg_wdata & MASK_TRANSMIT_STATUS) | RST_TRANSMIT_STATUS;
      else if (sel_divisor)
        divisor_q <= reg_wdata;
    end
  end

  // width select and link clear change only while the receiver is held off,
  // so the link domain sees nine_q as a constant and needs no synchroniser
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      link_clr_q <= 1'b1;
      nine_q     <= 1'b0;
    end
    else
    begin
      link_clr_q <= !rx_enable;
      if (link_clr_q)
        nine_q <= receive_status_control_q[BIT_NINE_BIT_SELECT];
    end
  end

  // register reads; framing error cannot occur without start and stop bits
  always_comb
  begin
    if (sel_interrupt_control)
      rdata_d = interrupt_control_q;
    else if (sel_pflags)
      rdata_d = pflags_q | (8'(receive_irq_flag) << BIT_RECEIVE_IRQ_FLAG);
    else if (sel_receive_status_control)
      rdata_d = {receive_status_control_q[7:3], 1'b0, overrun_error_q, received_ninth_bit};
    else if (sel_rcdata)
      rdata_d = head[DATA_W-1:0];
    else if (sel_pie)
      rdata_d = pie_q;
    else if (sel_transmit_status_control)
      rdata_d = transmit_status_control_q;
    else if (sel_divisor)
      rdata_d = divisor_q;
    else
      rdata_d = 8'h00;
  end

  wire irq_d  = global_irq_enable && peripheral_irq_enable && receive_irq_enable && receive_irq_flag;
  wire wake_d = sleep && receive_irq_enable && receive_irq_flag;

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      rdata_q  <= 8'h00;
      irq_q    <= 1'b0;
      wake_q   <= 1'b0;
      vector_q <= 13'h0000;
    end
    else
    begin
      rdata_q  <= reg_re ? rdata_d : 8'h00;
      irq_q    <= irq_d;
      wake_q   <= wake_d;
      vector_q <= irq_d ? IRQ_VECTOR : 13'h0000;
    end
  end

  assign reg_rdata  = rdata_q;
  assign irq        = irq_q;
  assign wake       = wake_q;
  assign irq_vector = vector_q;

endmodule

// *** verification/usync_checker.sv ***
// concurrent checks on the shift link and the receiver's interrupt outputs
`timescale 1ns/1ns
module usync_checker
  import usync_pkg::*;
(
  input wire logic        clk,
  input wire logic        rst,
  input wire logic        shift_clk,
  input wire logic        data,
  input wire logic        word_valid,
  input wire logic        word_ready,
  input wire logic        nine_bit,
  input wire logic        sleep,
  input wire logic        irq,
  input wire logic        wake,
  input wire logic [12:0] irq_vector
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);

  logic       sc_prev_q;
  logic       busy_q;
  logic       nine_q;
  logic [3:0] rises_q;

  // busy_q keeps the post-reset rise of word_ready out of the bit count check
  always_ff @(posedge clk)
  begin
    sc_prev_q <= shift_clk;
    if (rst || (word_valid && word_ready))
      rises_q <= 4'h0;
    else if (shift_clk && !sc_prev_q)
      rises_q <= rises_q + 4'h1;
    if (rst)
      busy_q <= 1'b0;
    else if (word_valid && word_ready)
      busy_q <= 1'b1;
    else if (word_ready)
      busy_q <= 1'b0;
    if (word_valid && word_ready)
      nine_q <= nine_bit;
  end

  sequence handshake_s;
    word_valid && word_ready;
  endsequence

  sequence first_edge_s;
    !shift_clk ##1 !shift_clk ##1 shift_clk;
  endsequence

  AST_FIRST_EDGE: assert property (handshake_s |=> first_edge_s)
    else $error("first shift clock edge off its slot");
  AST_READY_DROP: assert property (handshake_s |=> !word_ready)
    else $error("master stayed ready after taking a word");
  AST_WORD_DONE: assert property (handshake_s |-> ##[2:60] word_ready)
    else $error("master word did not finish in time");
  AST_BIT_COUNT: assert property (busy_q && word_ready |->
    rises_q == (nine_q ? 4'h9 : 4'h8))
    else $error("wrong number of shift clock edges in a word");
  AST_IDLE_LOW: assert property (word_ready |-> !shift_clk)
    else $error("shift clock not low while master idle");
  AST_DATA_HOLD: assert property (shift_clk && $past(shift_clk) |-> $stable(data))
    else $error("data moved while shift clock high");
  AST_VECTOR: assert property (irq |-> irq_vector == IRQ_VECTOR)
    else $error("vector wrong during interrupt");
  AST_NO_VECTOR: assert property (!irq |-> irq_vector == 13'h0000)
    else $error("vector shown without interrupt");
  AST_WAKE_SLEEP: assert property (!sleep |=> !wake)
    else $error("wake raised while awake");
endmodule

// *** verification/usart_sync_slave_receiver_tb.sv ***
// testbench: master and slave receiver joined by the link, register-level tests
`timescale 1ns/1ns
module usart_sync_slave_receiver_tb
  import usync_pkg::*;
;
  logic        clk;
  logic        rst;
  logic        word_valid;
  logic [8:0]  word_data;
  logic        nine_bit;
  logic        word_ready;
  logic [7:0]  reg_addr;
  logic [7:0]  reg_wdata;
  logic        reg_we;
  logic        reg_re;
  logic        sleep;
  logic [7:0]  reg_rdata;
  logic        irq;
  logic        wake;
  logic [12:0] irq_vector;
  int          n_fail;
  int          compares;
  int          cycles;
  logic [7:0]  ra [8];
  logic [7:0]  rv [8];

  sync_link_if i_sync_link_if ();

  usync_master_tx i_usync_master_tx (.clk(clk), .rst(rst), .link(i_sync_link_if),
    .word_valid(word_valid), .word_data(word_data), .nine_bit(nine_bit),
    .word_ready(word_ready));

  usync_slave_rx i_usync_slave_rx (.clk(clk), .rst(rst), .link(i_sync_link_if),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_we(reg_we), .reg_re(reg_re),
    .sleep(sleep), .reg_rdata(reg_rdata), .irq(irq), .wake(wake),
    .irq_vector(irq_vector));

  usync_checker i_usync_checker (.clk(clk), .rst(rst),
    .shift_clk(i_sync_link_if.shift_clk), .data(i_sync_link_if.data),
    .word_valid(word_valid), .word_ready(word_ready), .nine_bit(nine_bit),
    .sleep(sleep), .irq(irq), .wake(wake), .irq_vector(irq_vector));

  always #5 clk = ~clk;

  task automatic conclude();
    $display("compares=%0d n_fail=%0d", compares, n_fail);
    if (n_fail == 0 && compares > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  // whole-run ceiling, well above the few hundred cycles the tests need
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 8000)
    begin
      n_fail++;
      conclude();
    end
  end

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_we <= 1'b1;
    @(posedge clk);
    reg_we <= 1'b0;
  endtask

  // read data stands for the single cycle after the read is taken
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clk);
    reg_addr <= a;
    reg_re <= 1'b1;
    @(posedge clk);
    reg_re <= 1'b0;
    #1;
    check({8'h00, reg_rdata}, {8'h00, exp});
  endtask

  task automatic send(input logic [8:0] w, input logic nb);
    int n;
    n = 0;
    @(posedge clk);
    word_data <= w;
    nine_bit <= nb;
    word_valid <= 1'b1;
    @(posedge clk);
    while (word_ready !== 1'b1 && n < 100)
    begin
      @(posedge clk);
      n++;
    end
    word_valid <= 1'b0;
  endtask

  // wait for the master to go idle, then for the word to reach the flag
  task automatic settle();
    int n;
    n = 0;
    @(posedge clk);
    while (word_ready !== 1'b1 && n < 100)
    begin
      @(posedge clk);
      n++;
    end
    repeat (8) @(posedge clk);
  endtask

  initial
  begin
    clk = 1'b0;
    rst = 1'b1;
    word_valid = 1'b0;
    word_data = 9'h000;
    nine_bit = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    reg_we = 1'b0;
    reg_re = 1'b0;
    sleep = 1'b0;
    ra = '{ADDR_INTERRUPT_CONTROL, ADDR_PERIPH_IRQ_FLAGS, ADDR_RECEIVE_STATUS,
      ADDR_RECEIVE_DATA, ADDR_PERIPH_IRQ_ENABLES, ADDR_TRANSMIT_STATUS,
      ADDR_BIT_RATE_DIVISOR, 8'h50};
    rv = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h02, 8'h00, 8'h00};
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    foreach (ra[i]) rd(ra[i], rv[i]);
    wr(ADDR_TRANSMIT_STATUS, 8'h12);
    rd(ADDR_TRANSMIT_STATUS, 8'h12);
    wr(ADDR_RECEIVE_STATUS, 8'hA0);
    send(9'h0A5, 1'b0);
    settle();
    rd(ADDR_PERIPH_IRQ_FLAGS, 8'h00);
    // clock source set: the port would drive the clock itself, so no slave reception
    wr(ADDR_TRANSMIT_STATUS, 8'h92);
    rd(ADDR_TRANSMIT_STATUS, 8'h92);
    wr(ADDR_RECEIVE_STATUS, 8'h90);
    send(9'h0A5, 1'b0);
    settle();
    rd(ADDR_PERIPH_IRQ_FLAGS, 8'h00);
    wr(ADDR_TRANSMIT_STATUS, 8'h12);
    wr(ADDR_PERIPH_IRQ_ENABLES, 8'h20);
    wr(ADDR_INTERRUPT_CONTROL, 8'h40);
    wr(ADDR_RECEIVE_STATUS, 8'h90);
    repeat (3) @(posedge clk);
    sleep <= 1'b1;
    send(9'h03C, 1'b0);
    settle();
    rd(ADDR_PERIPH_IRQ_FLAGS, 8'h20);
    check({15'h0000, irq}, 16'h0000);
    check({15'h0000, wake}, 16'h0001);
    wr(ADDR_INTERRUPT_CONTROL, 8'hC0);
    repeat (2) @(posedge clk);
    #1;
    check({15'h0000, irq}, 16'h0001);
    check({3'h0, irq_vector}, 16'h0004);
    @(posedge clk);
    sleep <= 1'b0;
    rd(ADDR_RECEIVE_STATUS, 8'h90);
    rd(ADDR_RECEIVE_DATA, 8'h3C);
    repeat (2) @(posedge clk);
    #1;
    check({15'h0000, irq}, 16'h0000);
    wr(ADDR_RECEIVE_STATUS, 8'h80);
    wr(ADDR_RECEIVE_STATUS, 8'hD0);
    repeat (3) @(posedge clk);
    send(9'h1AB, 1'b1);
    send(9'h055, 1'b1);
    settle();
    rd(ADDR_RECEIVE_STATUS, 8'hD1);
    rd(ADDR_RECEIVE_DATA, 8'hAB);
    rd(ADDR_RECEIVE_STATUS, 8'hD0);
    rd(ADDR_RECEIVE_DATA, 8'h55);
    send(9'h011, 1'b1);
    send(9'h022, 1'b1);
    send(9'h033, 1'b1);
    settle();
    rd(ADDR_RECEIVE_STATUS, 8'hD2);
    rd(ADDR_RECEIVE_DATA, 8'h11);
    wr(ADDR_RECEIVE_STATUS, 8'hC0);
    rd(ADDR_RECEIVE_STATUS, 8'hC0);
    rd(ADDR_RECEIVE_DATA, 8'h00);
    conclude();
  end
endmodule
